// ===== rtl/farr_pkg.sv
package farr_pkg;

  // locally stored monitoring area (decimal base 51967)
  localparam logic [15:0] LOCAL_BASE      = 16'hcaff;
  localparam logic [15:0] LOCAL_FIRST     = 16'hcb00;
  localparam logic [3:0]  PARAM_STATUS    = 4'h1;
  localparam logic [3:0]  PARAM_FAULT     = 4'h2;
  localparam logic [3:0]  PARAM_WARN      = 4'h3;
  localparam logic [3:0]  PARAM_LOCAL     = 4'ha;
  localparam logic [3:0]  PARAM_SENS_HI   = 4'hb;
  localparam logic [3:0]  PARAM_SENS_LO   = 4'hc;
  localparam logic [7:0]  LOCAL_SPAN_MAX  = 8'h0e;

  // relay windows
  localparam int          RELAY_WIN_SHIFT = 9;
  localparam logic [15:0] RELAY_WIN_SIZE  = 16'h0200;
  localparam logic [15:0] FAN_REG_BASE    = 16'hd000;
  localparam logic [7:0]  RELAY_SPAN_MAX  = 8'h09;
  localparam logic [6:0]  MAX_FANS        = 7'h64;

  // slave identity and memory shape
  localparam logic [7:0]  SLAVE_ADDR_RST  = 8'h01;
  localparam int          MEM_AW          = 11;
  localparam int          MEM_DEPTH       = 2048;
  localparam int          DATA_W          = 16;

  // exception codes
  localparam logic [7:0]  EXC_NONE        = 8'h00;
  localparam logic [7:0]  EXC_FUNCTION    = 8'h01;
  localparam logic [7:0]  EXC_ADDRESS     = 8'h02;
  localparam logic [7:0]  EXC_VALUE       = 8'h03;
  localparam logic [7:0]  EXC_FAN_FAIL    = 8'h04;
  localparam logic [7:0]  EXC_NO_RESPONSE = 8'h0b;

  // fan status codes and link outcome codes
  localparam logic [1:0]  STAT_NO_COMMS   = 2'h0;
  localparam logic [1:0]  STAT_HEALTHY    = 2'h1;
  localparam logic [1:0]  STAT_ALARM      = 2'h2;
  localparam logic [1:0]  STAT_WARNING    = 2'h3;
  localparam logic [1:0]  LINK_OK         = 2'h0;
  localparam logic [1:0]  LINK_FAIL       = 2'h1;
  localparam logic [1:0]  LINK_NO_COMMS   = 2'h2;

  // bits that carry meaning; the rest read as zero
  localparam logic [15:0] FAULT_LIVE_MASK = 16'h15f7;
  localparam logic [15:0] WARN_LIVE_MASK  = 16'hdeff;

  typedef struct packed {
    logic [7:0]  slave;
    logic        write;
    logic [15:0] addr;
    logic [7:0]  count;
  } farr_req_t;

  typedef struct packed {
    logic [6:0]  fan;
    logic        write;
    logic [15:0] reg_addr;
    logic [7:0]  count;
  } farr_fan_req_t;

  typedef struct packed {
    logic [6:0]  fan;
    logic [3:0]  param;
    logic [15:0] data;
  } farr_upd_t;

  typedef struct packed {
    logic [2:0] zero_hi;
    logic       link_voltage_low;
    logic       zero_11;
    logic       rotor_sensor_calibration;
    logic       zero_9;
    logic       overspeed;
    logic       motor_blocked;
    logic       hall_sensor_fault;
    logic       motor_overheat_fault;
    logic       internal_comm_fault;
    logic       zero_3;
    logic       general_fan_fault;
    logic       output_stage_overheat_fault;
    logic       phase_or_line_failure;
  } farr_fault_t;

  typedef struct packed {
    logic shedding_active;
    logic line_voltage_high;
    logic zero_13;
    logic link_voltage_high;
    logic heating_active;
    logic input_cable_break;
    logic speed_below_limit;
    logic reserved_8;
    logic brake_operation;
    logic link_voltage_low;
    logic electronics_interior_hot;
    logic motor_hot_warning;
    logic output_stage_hot_warning;
    logic power_limiter_on;
    logic line_impedance_high;
    logic current_limiter_on;
  } farr_warn_t;

endpackage

// ===== rtl/farr_word_mem.sv
`timescale 1ns/1ps
module farr_word_mem
  import farr_pkg::*;
(
  input  wire logic              clk,     // system clock
  input  wire logic              wr_en,   // write strobe
  input  wire logic [MEM_AW-1:0] wr_addr, // write index
  input  wire logic [DATA_W-1:0] wr_data, // write word
  input  wire logic              rd_en,   // read strobe
  input  wire logic [MEM_AW-1:0] rd_addr, // read index
  output logic      [DATA_W-1:0] rd_data  // registered read word
);

  logic [DATA_W-1:0] mem [MEM_DEPTH];

  // one write and one registered read per cycle
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule // farr_word_mem

// ===== rtl/farr_relay.sv
`timescale 1ns/1ps
// How it works
// - parameter p of fan f lives at 51967 + p*N - (N - f).
// - sensor high word at 51967 + 10N + 2f - 1, low word right after.
// - sensor reading is two words, high first, present only with fan sensor input.
// - local access spanning more than 14 registers gets an exception.
// - fault word upper byte: 15,14,13,11,9 zero; 12,10,8 meaningful faults.
// - fault word lower byte: bit 3 zero, other bits are fan faults.
// - warning word upper byte: bit 13 zero, bit 8 reserved, others warnings.
// - warning word lower byte: all eight bits are live warnings.
// - each fan's registers appear inside its window at our slave address.
// - fan n window starts at n times 200 hex, fans 1 to 100.
// - window offset equals fan register address minus D000 hex.
// - relay keeps no copy; every access runs a fan transaction.
// - the answer to the master waits for the fan transaction.
// - fan failure or fan without comms gives an exception.
// - relay access spanning more than 9 registers gets an exception.
// - answer only at our configurable slave address, default 1.
// - fan status codes: 0 no comms, 1 healthy, 2 alarm, 3 warning.
module farr_relay
  import farr_pkg::*;
(
  input  wire logic          CLK,             // 250 MHz clock
  input  wire logic          RST,             // sync reset, active high
  input  wire logic          CFG_ADDR_WE,     // load new slave address
  input  wire logic [7:0]    CFG_ADDR,        // new slave address
  input  wire logic [6:0]    TOTAL_FANS,      // connected fans, 1..100
  input  wire logic          RELAY_MODE,      // relay operation selected
  input  wire logic          SENSOR_FROM_FAN, // fans are the sensor source
  input  wire logic          REQ_VALID,       // decoded master request
  input  wire farr_req_t     REQ,             // request fields
  output logic               REQ_READY,       // idle, request may be taken
  input  wire logic          MW_VALID,        // master write word strobe
  input  wire logic [15:0]   MW_DATA,         // master write word
  output logic               RSP_WORD_VALID,  // read word strobe
  output logic [15:0]        RSP_WORD,        // read word
  output logic               RSP_DONE,        // answer complete pulse
  output logic [7:0]         RSP_EXC,         // exception code, 0 = none
  input  wire logic          UPD_VALID,       // fan poll result strobe
  input  wire farr_upd_t     UPD,             // fan poll result
  output logic               FAN_REQ_VALID,   // fan transaction start pulse
  output farr_fan_req_t      FAN_REQ,         // fan transaction fields
  output logic               FAN_WVALID,      // write word to fan
  output logic [15:0]        FAN_WDATA,       // write word data
  input  wire logic          FAN_RVALID,      // read word from fan
  input  wire logic [15:0]   FAN_RDATA,       // read word data
  input  wire logic          FAN_DONE,        // fan transaction finished
  input  wire logic [1:0]    FAN_STAT,        // fan transaction outcome
  output logic [7:0]         SLAVE_ADDR       // current slave address
);

  typedef enum logic [2:0] {ST_IDLE, ST_LREAD, ST_RSEND, ST_RWAIT, ST_FIN} farr_state_t;

  farr_state_t      st_r;
  farr_state_t      st_nxt;
  logic [7:0]       exc_r;
  logic [7:0]       exc_nxt;
  logic [15:0]      hold_addr_r;
  logic             hold_wr_r;
  logic [7:0]       rem_r;
  logic [MEM_AW-1:0] rd_addr_r;
  logic             rd_pend_r;
  logic             rd_en;
  logic [15:0]      mem_q;
  logic             accept;
  logic             is_local;
  logic [15:0]      loc_idx;
  logic [16:0]      loc_end;
  logic [15:0]      loc_limit;
  logic [6:0]       win_fan;
  logic [16:0]      win_end;
  logic             relay_hit;
  logic             upd_ok;
  logic [15:0]      upd_idx;
  logic [15:0]      upd_word;
  farr_fault_t      upd_fault;
  farr_warn_t       upd_warn;

  // request taken only in idle and only at our own address
  assign accept = (st_r == ST_IDLE) && REQ_VALID && (REQ.slave == SLAVE_ADDR);

  // local area decode; sensor words exist only when fans supply them
  assign is_local  = REQ.addr >= LOCAL_FIRST;
  assign loc_idx   = REQ.addr - LOCAL_FIRST;
  assign loc_end   = {1'b0, loc_idx} + {9'h000, REQ.count};
  assign loc_limit = SENSOR_FROM_FAN ? 16'(TOTAL_FANS) * 16'(PARAM_SENS_LO)
                                     : 16'(TOTAL_FANS) * 16'(PARAM_LOCAL);

  // relay window decode: fan number from the top bits, offset below
  assign win_fan   = REQ.addr[15:RELAY_WIN_SHIFT];
  assign win_end   = {8'h00, REQ.addr[RELAY_WIN_SHIFT-1:0]} + {9'h000, REQ.count};
  assign relay_hit = RELAY_MODE && (win_fan != 7'h00) && (win_fan <= TOTAL_FANS)
                     && (win_fan <= MAX_FANS);

  // decision in idle: span faults first, then address, then function
  always_comb begin
    st_nxt  = st_r;
    exc_nxt = exc_r;
    unique case (st_r)
      ST_IDLE: begin
        if (accept) begin
          st_nxt  = ST_FIN;
          exc_nxt = EXC_NONE;
          if (REQ.count == 8'h00) begin
            exc_nxt = EXC_VALUE;
          end else if (is_local) begin
            if (REQ.count > LOCAL_SPAN_MAX) begin
              exc_nxt = EXC_VALUE;
            end else if (loc_end > {1'b0, loc_limit}) begin
              exc_nxt = EXC_ADDRESS;
            end else if (REQ.write) begin
              exc_nxt = EXC_FUNCTION;
            end else begin
              st_nxt = ST_LREAD;
            end
          end else if (REQ.count > RELAY_SPAN_MAX) begin
            exc_nxt = EXC_VALUE;
          end else if (!relay_hit || win_end > {1'b0, RELAY_WIN_SIZE}) begin
            exc_nxt = EXC_ADDRESS;
          end else begin
            st_nxt = ST_RSEND;
          end
        end
      end
      ST_LREAD: begin
        if (rem_r == 8'h00 && !rd_pend_r) begin
          st_nxt = ST_FIN;
        end
      end
      ST_RSEND: st_nxt = ST_RWAIT;
      ST_RWAIT: begin
        if (FAN_DONE) begin
          st_nxt  = ST_FIN;
          exc_nxt = (FAN_STAT == LINK_OK) ? EXC_NONE :
                    (FAN_STAT == LINK_NO_COMMS) ? EXC_NO_RESPONSE : EXC_FAN_FAIL;
        end
      end
      ST_FIN: st_nxt = ST_IDLE;
    endcase
  end

  // state and ready flag
  always_ff @(posedge CLK) begin
    if (RST) begin
      st_r      <= ST_IDLE;
      exc_r     <= EXC_NONE;
      REQ_READY <= 1'b0;
    end else begin
      st_r      <= st_nxt;
      exc_r     <= exc_nxt;
      REQ_READY <= (st_nxt == ST_IDLE);
    end
  end

  // slave address, loaded by configuration, factory value after reset
  always_ff @(posedge CLK) begin
    if (RST) begin
      SLAVE_ADDR <= SLAVE_ADDR_RST;
    end else if (CFG_ADDR_WE) begin
      SLAVE_ADDR <= CFG_ADDR;
    end
  end

  // request capture and local read walk
  assign rd_en = (st_r == ST_LREAD) && (rem_r != 8'h00);
  always_ff @(posedge CLK) begin
    if (RST) begin
      hold_addr_r <= 16'h0000;
      hold_wr_r   <= 1'b0;
      rem_r       <= 8'h00;
      rd_addr_r   <= '0;
      rd_pend_r   <= 1'b0;
    end else begin
      rd_pend_r <= rd_en;
      if (accept) begin
        hold_addr_r <= REQ.addr;
        hold_wr_r   <= REQ.write;
        rem_r       <= REQ.count;
        rd_addr_r   <= loc_idx[MEM_AW-1:0];
      end else if (rd_en) begin
        rem_r     <= rem_r - 8'h01;
        rd_addr_r <= rd_addr_r + MEM_AW'(1);
      end
    end
  end

  // poll results land at index (p-1)*N + f-1, sensor pairs after param 10
  assign upd_ok = UPD_VALID && (UPD.fan != 7'h00) && (UPD.fan <= TOTAL_FANS)
                  && (UPD.param != 4'h0) && (UPD.param <= PARAM_SENS_LO);
  always_comb begin
    if (UPD.param <= PARAM_LOCAL) begin
      upd_idx = 16'(UPD.param - 4'h1) * 16'(TOTAL_FANS) + 16'(UPD.fan) - 16'h0001;
    end else begin
      upd_idx = 16'(PARAM_LOCAL) * 16'(TOTAL_FANS) + 16'({UPD.fan, 1'b0}) - 16'h0002
                + ((UPD.param == PARAM_SENS_LO) ? 16'h0001 : 16'h0000);
    end
  end

  // status clipped to its code; unused fault and warning bits forced low
  always_comb begin
    unique case (UPD.param)
      PARAM_STATUS: upd_word = {14'h0000, UPD.data[1:0]};
      PARAM_FAULT:  upd_word = UPD.data & FAULT_LIVE_MASK;
      PARAM_WARN:   upd_word = UPD.data & WARN_LIVE_MASK;
      default:      upd_word = UPD.data;
    endcase
  end

  farr_word_mem u_mem (
    .clk     (CLK),
    .wr_en   (upd_ok),
    .wr_addr (upd_idx[MEM_AW-1:0]),
    .wr_data (upd_word),
    .rd_en   (rd_en),
    .rd_addr (rd_addr_r),
    .rd_data (mem_q)
  );

  // answer path: memory words or words passed straight from the fan
  always_ff @(posedge CLK) begin
    if (RST) begin
      RSP_WORD_VALID <= 1'b0;
      RSP_WORD       <= 16'h0000;
      RSP_DONE       <= 1'b0;
      RSP_EXC        <= EXC_NONE;
    end else begin
      RSP_DONE <= (st_r == ST_FIN);
      if (st_r == ST_FIN) begin
        RSP_EXC <= exc_r;
      end
      if (st_r == ST_RWAIT) begin
        RSP_WORD_VALID <= FAN_RVALID && !hold_wr_r;
        RSP_WORD       <= FAN_RDATA;
      end else begin
        RSP_WORD_VALID <= rd_pend_r;
        RSP_WORD       <= mem_q;
      end
    end
  end

  // fan side: one start pulse, then write words pass through uncached
  always_ff @(posedge CLK) begin
    if (RST) begin
      FAN_REQ_VALID <= 1'b0;
      FAN_REQ       <= '0;
      FAN_WVALID    <= 1'b0;
      FAN_WDATA     <= 16'h0000;
    end else begin
      FAN_REQ_VALID <= (st_r == ST_RSEND);
      if (st_r == ST_RSEND) begin
        FAN_REQ.fan      <= hold_addr_r[15:RELAY_WIN_SHIFT];
        FAN_REQ.write    <= hold_wr_r;
        FAN_REQ.reg_addr <= FAN_REG_BASE + {7'h00, hold_addr_r[RELAY_WIN_SHIFT-1:0]};
        FAN_REQ.count    <= rem_r;
      end
      FAN_WVALID <= MW_VALID && hold_wr_r && (st_r == ST_RWAIT);
      FAN_WDATA  <= MW_DATA;
    end
  end

  // struct views of the stored word, so the checks below can name bits
  assign upd_fault = upd_word;
  assign upd_warn  = upd_word;

  a_fault_zero_bits: assert property (@(posedge CLK) disable iff (RST)
    upd_ok && UPD.param == PARAM_FAULT |-> upd_fault.zero_hi == 3'h0
      && !upd_fault.zero_11 && !upd_fault.zero_9
      && upd_fault.link_voltage_low == UPD.data[12])
    else $error("fault word unused bit not cleared");

  a_fault_low_byte: assert property (@(posedge CLK) disable iff (RST)
    upd_ok && UPD.param == PARAM_FAULT |-> !upd_fault.zero_3
      && upd_fault.motor_blocked == UPD.data[7])
    else $error("fault low byte wrong");

  a_warn_zero_bits: assert property (@(posedge CLK) disable iff (RST)
    upd_ok && UPD.param == PARAM_WARN |-> !upd_warn.zero_13
      && !upd_warn.reserved_8
      && upd_warn.shedding_active == UPD.data[15])
    else $error("warning word unused bit not cleared");

  a_local_span: assert property (@(posedge CLK) disable iff (RST)
    accept && is_local && REQ.count > LOCAL_SPAN_MAX |-> ##2 RSP_DONE && RSP_EXC == EXC_VALUE)
    else $error("long local access not refused");

  a_relay_span: assert property (@(posedge CLK) disable iff (RST)
    accept && !is_local && REQ.count > RELAY_SPAN_MAX
      |-> ##2 RSP_DONE && RSP_EXC == EXC_VALUE && !FAN_REQ_VALID)
    else $error("long relay access not refused");

  a_relay_map: assert property (@(posedge CLK) disable iff (RST)
    accept && st_nxt == ST_RSEND |-> ##2 FAN_REQ_VALID
      && FAN_REQ.reg_addr == FAN_REG_BASE + {7'h00, $past(REQ.addr[8:0], 2)}
      && FAN_REQ.fan == $past(win_fan, 2))
    else $error("relay window mapped to wrong fan register");

  a_relay_withhold: assert property (@(posedge CLK) disable iff (RST)
    st_r == ST_RWAIT && !FAN_DONE |-> ##2 !RSP_DONE)
    else $error("answer sent before fan transaction finished");

  a_fan_fail_exc: assert property (@(posedge CLK) disable iff (RST)
    st_r == ST_RWAIT && FAN_DONE && FAN_STAT != LINK_OK
      |-> ##2 RSP_DONE && RSP_EXC != EXC_NONE)
    else $error("failed fan transaction answered without exception");

  a_slave_ignore: assert property (@(posedge CLK) disable iff (RST)
    st_r == ST_IDLE && REQ_VALID && REQ.slave != SLAVE_ADDR |=> st_r == ST_IDLE ##1 !RSP_DONE)
    else $error("request for another slave was answered");

  a_beyond_fans: assert property (@(posedge CLK) disable iff (RST)
    accept && !is_local && REQ.count <= RELAY_SPAN_MAX && REQ.count != 8'h00
      && win_fan > TOTAL_FANS |-> ##2 RSP_DONE && RSP_EXC == EXC_ADDRESS)
    else $error("window of absent fan not refused");

endmodule // farr_relay

// ===== bench/farr_fan_model.sv
`timescale 1ns/1ps
module farr_fan_model
  import farr_pkg::*;
(
  input  wire logic          clk,       // system clock
  input  wire logic          req_valid, // transaction start pulse
  input  wire farr_fan_req_t req,       // transaction fields
  input  wire logic [7:0]    dly,       // answer delay in cycles
  input  wire logic [1:0]    stat,      // outcome to report
  output logic               rvalid,    // read word strobe
  output logic [15:0]        rdata,     // read word
  output logic               done,      // transaction finished
  output logic [1:0]         stat_o     // outcome code
);
  farr_fan_req_t cur;

  // slow or quick fan; a failing fan sends no words before reporting
  initial begin
    rvalid = 1'b0;
    rdata  = 16'h0;
    done   = 1'b0;
    stat_o = 2'h0;
    forever begin
      @(posedge clk);
      if (req_valid === 1'b1) begin
        cur = req; // every access is answered fresh, nothing cached
        repeat (dly) @(posedge clk);
        for (int i = 0; i < int'(cur.count); i++) begin
          if (!cur.write && stat == LINK_OK) begin
            #1 rvalid = 1'b1;
            rdata = {cur.fan, cur.reg_addr[8:0]} + 16'(i);
            @(posedge clk);
          end
        end
        #1 rvalid = 1'b0;
        rdata  = ~rdata; // released data does not keep the last word
        done   = 1'b1;
        stat_o = stat;
        @(posedge clk);
        #1 done = 1'b0;
        stat_o = ~stat;
      end
    end
  end
endmodule // farr_fan_model

// ===== bench/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import farr_pkg::*;
;
  logic          clk, rst, cfg_we, relay, sens, req_valid, req_ready, mw_valid, got;
  logic          rsp_wv, rsp_done, upd_valid, fan_req_valid, fan_wvalid, fan_rvalid, fan_done;
  logic [7:0]    cfg_addr, rsp_exc, slave_addr, dly, sa, exc;
  logic [6:0]    n_fans;
  logic [15:0]   mw_data, rsp_word, fan_wdata, fan_rdata, wval, d, e;
  logic [1:0]    fan_stat, stat;
  farr_req_t     req;
  farr_upd_t     upd;
  farr_fan_req_t fan_req, last_freq;
  logic [15:0]   rq[$], wq[$];
  int            error_cnt, n_compared, n_txn, cyc, t_fdone, t_rsp;
  int            fl[4] = '{1, 2, 4, 100};
  int            ol[4] = '{0, 0, 1, 0};

  farr_relay dut (
    .CLK(clk), .RST(rst), .CFG_ADDR_WE(cfg_we), .CFG_ADDR(cfg_addr),
    .TOTAL_FANS(n_fans), .RELAY_MODE(relay), .SENSOR_FROM_FAN(sens),
    .REQ_VALID(req_valid), .REQ(req), .REQ_READY(req_ready),
    .MW_VALID(mw_valid), .MW_DATA(mw_data), .RSP_WORD_VALID(rsp_wv),
    .RSP_WORD(rsp_word), .RSP_DONE(rsp_done), .RSP_EXC(rsp_exc),
    .UPD_VALID(upd_valid), .UPD(upd), .FAN_REQ_VALID(fan_req_valid),
    .FAN_REQ(fan_req), .FAN_WVALID(fan_wvalid), .FAN_WDATA(fan_wdata),
    .FAN_RVALID(fan_rvalid), .FAN_RDATA(fan_rdata), .FAN_DONE(fan_done),
    .FAN_STAT(fan_stat), .SLAVE_ADDR(slave_addr));

  farr_fan_model fans (
    .clk(clk), .req_valid(fan_req_valid), .req(fan_req), .dly(dly), .stat(stat),
    .rvalid(fan_rvalid), .rdata(fan_rdata), .done(fan_done), .stat_o(fan_stat));

  // clock and cycle stamp for latency checks
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // fan done stamped at the edge the design samples it, free of model races
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (fan_done === 1'b1) t_fdone <= cyc;
  end

  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  // local address of parameter p for fan f
  function automatic logic [15:0] laddr(int p, int f);
    return 16'(51967 + p * int'(n_fans) - (int'(n_fans) - f));
  endfunction

  task automatic upd_w(logic [6:0] f, logic [3:0] p, logic [15:0] v);
    upd_valid = 1'b1;
    upd = '{fan: f, param: p, data: v};
    tick();
    upd_valid = 1'b0;
  endtask

  // one master request; lim bounds the wait, short lim expects silence
  task automatic xfer(logic [15:0] a, logic [7:0] cnt, logic wr, int lim);
    int k;
    int m;
    m = 0;
    got = 1'b0;
    n_txn = 0;
    rq = {};
    wq = {};
    for (k = 0; k < 50 && req_ready !== 1'b1; k++) tick();
    if (req_ready !== 1'b1) begin
      error_cnt++;
      stop_test();
    end
    req_valid = 1'b1;
    req = '{slave: sa, write: wr, addr: a, count: cnt};
    tick();
    req_valid = 1'b0;
    for (k = 0; k < lim && !got; k++) begin
      if (fan_req_valid === 1'b1) begin
        n_txn++;
        last_freq = fan_req;
        m = wr ? int'(cnt) : 0;
      end
      if (fan_wvalid === 1'b1) wq.push_back(fan_wdata);
      if (rsp_wv === 1'b1) rq.push_back(rsp_word);
      got = (rsp_done === 1'b1);
      exc = rsp_exc;
      t_rsp = cyc;
      mw_valid = (m > 0);
      mw_data = wval;
      m = (m > 0) ? m - 1 : 0;
      if (!got) tick();
    end
    if (!got && lim > 20) begin
      error_cnt++;
      stop_test();
    end
  endtask

  initial begin
    {rst, cfg_we, relay, req_valid, mw_valid, upd_valid} = 6'h20;
    {cfg_addr, mw_data, wval, req, upd} = '0;
    {n_fans, sens, sa, dly, stat} = {7'h03, 1'b1, 8'h01, 8'h06, LINK_OK};
    repeat (4) tick();
    check("reset_addr", 16'(slave_addr), 16'h0001);
    rst = 1'b0;
    // status codes, fault and warning coding, plain values
    for (int q = 0; q < 4; q++) begin
      upd_w(7'h01, 4'h1, 16'(q));
      xfer(16'hcb00, 8'h01, 1'b0, 400);
      check("status", rq[0], 16'(q));
    end
    for (int p = 1; p <= 10; p++) begin
      d = (p < 4) ? 16'hffff : {4'(p), 12'h5a3};
      e = (p == 2) ? ~16'hea08 : (p == 3) ? ~16'h2100 : (p == 1) ? 16'h0003 : d;
      upd_w(7'h03, 4'(p), d);
      xfer(laddr(p, 3), 8'h01, 1'b0, 400);
      check("local_word", rq[0], e);
    end
    xfer(16'hcb00, 8'h0e, 1'b0, 400);
    check("span14", 16'(rq.size()), 16'h000e);
    xfer(16'hcb00, 8'h0f, 1'b0, 400);
    check("span15", 16'(exc), 16'(EXC_VALUE));
    xfer(16'hcb00, 8'h00, 1'b0, 400);
    check("span0", 16'(exc), 16'(EXC_VALUE));
    xfer(16'hcb00, 8'h01, 1'b1, 400);
    check("local_wr", 16'(exc), 16'(EXC_FUNCTION));
    $display("test local done");
    upd_w(7'h02, 4'hb, 16'h1234);
    upd_w(7'h02, 4'hc, 16'h5678);
    xfer(16'(51967 + 10 * 3 + 2 * 2 - 1), 8'h02, 1'b0, 400);
    check("sens_hi", rq[0], 16'h1234);
    check("sens_lo", rq[1], 16'h5678);
    sens = 1'b0;
    xfer(16'(51967 + 10 * 3 + 2 * 2 - 1), 8'h02, 1'b0, 400);
    check("sens_off", 16'(exc), 16'(EXC_ADDRESS));
    $display("test sensor done");
    sa = 8'h02;
    xfer(16'hcb00, 8'h01, 1'b0, 12);
    check("foreign", 16'(got), 16'h0000);
    {cfg_we, cfg_addr} = {1'b1, 8'h07};
    tick();
    cfg_we = 1'b0;
    check("cfg_addr", 16'(slave_addr), 16'h0007);
    sa = 8'h07;
    xfer(16'hcb00, 8'h01, 1'b0, 400);
    check("new_addr", 16'(got), 16'h0001);
    $display("test address done");
    xfer(16'h0600, 8'h01, 1'b0, 400);
    check("relay_off", 16'(exc), 16'(EXC_ADDRESS));
    relay = 1'b1;
    xfer(16'h0800, 8'h01, 1'b0, 400);
    check("fan_over_n", 16'(exc), 16'(EXC_ADDRESS));
    dly = 8'h14;
    repeat (2) begin
      xfer(16'h0605, 8'h04, 1'b0, 400);
      check("relay_txn", 16'(n_txn), 16'h0001);
      check("relay_reg", last_freq.reg_addr, 16'hd005);
      check("relay_cnt", 16'(last_freq.count), 16'h0004);
      check("relay_w3", rq[3], {7'h03, 9'h005} + 16'h3);
      check("reply_lag", 16'(t_rsp - t_fdone), 16'h0002);
    end
    dly = 8'h06;
    xfer(16'h0600, 8'h0a, 1'b0, 400);
    check("span10", {exc, 8'(n_txn)}, {EXC_VALUE, 8'h00});
    xfer(16'h0600, 8'h09, 1'b0, 400);
    check("span9", {exc, 8'(rq.size())}, {EXC_NONE, 8'h09});
    xfer(16'h07fc, 8'h05, 1'b0, 400);
    check("win_over", {exc, 8'(n_txn)}, {EXC_ADDRESS, 8'h00});
    stat = LINK_FAIL;
    xfer(16'h0600, 8'h01, 1'b0, 400);
    check("fan_fail", 16'(exc), 16'(EXC_FAN_FAIL));
    stat = LINK_NO_COMMS;
    xfer(16'h0600, 8'h01, 1'b0, 400);
    check("fan_silent", 16'(exc), 16'(EXC_NO_RESPONSE));
    stat = LINK_OK;
    $display("test relay done");
    n_fans = 7'h64;
    for (int i = 0; i < 4; i++) begin
      xfer(16'(fl[i] * 512 + ol[i]), 8'h01, 1'b0, 400);
      check("win_fan", 16'(last_freq.fan), 16'(fl[i]));
      check("win_reg", last_freq.reg_addr, 16'hd000 + 16'(ol[i]));
    end
    wval = 16'hffff; // full speed setpoint
    xfer(16'h0801, 8'h01, 1'b1, 400);
    check("wr_fan", {8'(last_freq.fan), 7'h0, last_freq.write}, 16'h0401);
    check("wr_reg", last_freq.reg_addr, 16'hd001);
    check("wr_word", wq[0], 16'hffff);
    $display("test windows done");
    stop_test();
  end
endmodule // tb_top
